// [bench/iefc_core_model.sv]
// Behavioural processor core that accepts and returns from interrupts
`timescale 1ns/1ps
module iefc_core_model (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire logic i_request,
    input wire logic i_auto,
    input wire logic [3:0] i_delay,
    input wire logic i_go_return,
    input wire logic i_ret_high,
    output logic o_accept = 1'b0,
    output logic o_return = 1'b0,
    output logic o_return_high = 1'b0
);
    // ------------------------------------------------------------
    // Accept after a set delay
    // ------------------------------------------------------------
    logic [3:0] wait_reg;
    // Only a request that stays up the whole delay is taken, so slow
    // responses never accept a request that has already gone
    always @(posedge i_clock) begin
        o_accept <= 1'b0;
        o_return <= i_go_return;
        o_return_high <= i_ret_high;
        if (!i_reset_n || !i_request || !i_auto || o_accept) begin
            wait_reg <= 4'h0;
        end else if (wait_reg == i_delay) begin
            o_accept <= 1'b1;
            wait_reg <= 4'h0;
        end else begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule // iefc_core_model

// [bench/iefc_props.sv]
// Port level checks of the interrupt enable and flag control
`timescale 1ns/1ps
module iefc_props (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] o_prdata,
    input wire o_pready,
    input wire o_pslverr,
    input wire i_irq_accept,
    input wire i_irq_return,
    input wire o_irq_request,
    input wire o_irq_high_level,
    input wire [23:0] o_vector_addr,
    input wire o_port_pullup_disable,
    input wire o_external_irq_one_edge,
    input wire o_external_irq_two_edge,
    input wire o_irq
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    wire acc_w = i_psel && i_penable;
    wire map_w = (i_paddr <= 12'h014) && (i_paddr[1:0] == 2'b00);
    wire sec_w = acc_w && i_pwrite && (i_paddr == 12'h004);
    wire rds_w = i_psel && !i_penable && !i_pwrite;
    wire [2:0] cfg_w = {o_port_pullup_disable, o_external_irq_one_edge,
        o_external_irq_two_edge};

    err_phase_a: assert property (o_pslverr |-> acc_w)
        else $error("slave error outside access phase");
    ready_now_a: assert property (acc_w |-> o_pready)
        else $error("access phase without ready");
    unmapped_err_a: assert property (acc_w && !map_w |-> o_pslverr)
        else $error("unmapped access not flagged");
    mapped_ok_a: assert property (acc_w && map_w |-> !o_pslverr)
        else $error("mapped access flagged as error");
    vector_sel_a: assert property (o_irq_request |->
        o_vector_addr == (o_irq_high_level ? 24'h00_0008 : 24'h00_0018))
        else $error("vector does not match level");
    accept_drop_a: assert property (o_irq_request && i_irq_accept
        && !i_irq_return |=> !o_irq_request)
        else $error("request survives its acceptance");
    reset_quiet_a: assert property ($rose(i_reset_n) |->
        !o_irq_request && !o_irq && cfg_w == 3'b111)
        else $error("outputs not at reset values");
    rdata_hold_a: assert property (!rds_w |=> $stable(o_prdata))
        else $error("read data moved without a read");
    cfg_hold_a: assert property (!sec_w |=> $stable(cfg_w))
        else $error("pin setup moved without a write");

    cover property (o_irq_request && i_irq_accept);
    cover property (o_irq_request && !o_irq_high_level);
    cover property (acc_w && o_pslverr);
endmodule // iefc_props

bind iefc_top iefc_props u_iefc_props (.i_clock, .i_reset_n, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pready, .o_pslverr,
    .i_irq_accept, .i_irq_return, .o_irq_request, .o_irq_high_level,
    .o_vector_addr, .o_port_pullup_disable, .o_external_irq_one_edge,
    .o_external_irq_two_edge, .o_irq);

// [bench/iefc_tb.sv]
// Self-checking bench for the interrupt enable and flag control
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module testbench;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic i_clock = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_psel = 1'b0;
    logic i_penable = 1'b0;
    logic i_pwrite = 1'b0;
    logic [11:0] i_paddr = 12'h000;
    logic [31:0] i_pwdata = 32'h0000_0000;
    logic tmr = 1'b0;
    logic x0_pin = 1'b0;
    logic [3:0] pb = 4'h0;
    logic pb_rd = 1'b0;
    logic p_lo = 1'b0;
    logic p_hi = 1'b0;
    logic auto = 1'b0;
    logic [3:0] dly = 4'h0;
    logic go_ret = 1'b0;
    logic ret_hi = 1'b0;
    wire [31:0] o_prdata;
    wire o_pready, o_pslverr, acc, ret, rhi;
    wire o_irq_request, o_irq_high_level, o_irq;
    wire [23:0] o_vector_addr;
    wire [2:0] cfg;
    logic [31:0] q;
    logic err;
    int n_fail = 0;
    int n_checks = 0;

    iefc_top u_iefc_top (.i_clock, .i_reset_n, .i_psel, .i_penable,
        .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
        .i_timer_zero_overflow(tmr), .i_external_irq_zero_pin(x0_pin),
        .i_port_b_pins(pb), .i_port_b_read(pb_rd), .i_periph_high_irq(p_hi),
        .i_periph_low_irq(p_lo), .i_irq_accept(acc), .i_irq_return(ret),
        .i_return_high(rhi), .o_irq_request, .o_irq_high_level,
        .o_vector_addr, .o_port_pullup_disable(cfg[2]),
        .o_external_irq_one_edge(cfg[1]), .o_external_irq_two_edge(cfg[0]),
        .o_irq);
    iefc_core_model u_iefc_core_model (.i_clock, .i_reset_n,
        .i_request(o_irq_request), .i_auto(auto), .i_delay(dly),
        .i_go_return(go_ret), .i_ret_high(ret_hi), .o_accept(acc),
        .o_return(ret), .o_return_high(rhi));

    initial begin
        forever #2.5 i_clock = ~i_clock;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [7:0] d);
        int k;
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= {24'h00_0000, d};
        @(posedge i_clock);
        i_penable <= 1'b1;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (o_pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            n_fail++;
            end_of_test();
        end
        q = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        `CHK(q, {24'h00_0000, e})
    endtask
    // Two edges after the pulse so the flag has settled when looked at
    task automatic pulse_tmr;
        tmr <= 1'b1;
        tick(1);
        tmr <= 1'b0;
        tick(2);
    endtask
    task automatic wait_req(input logic v);
        int k;
        k = 0;
        while (o_irq_request !== v && k < 32) begin
            tick(1);
            k++;
        end
        `CHK(o_irq_request, v)
    endtask
    task automatic do_return(input logic h);
        go_ret <= 1'b1;
        ret_hi <= h;
        tick(1);
        go_ret <= 1'b0;
        tick(3);
    endtask

    initial begin
        tick(20000);
        n_fail++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        tick(4);
        i_reset_n <= 1'b1;
        tick(4);
        rd(12'h000, 8'h00);
        rd(12'h004, 8'hF5);
        `CHK(cfg, 3'b111)
        apb(1'b1, 12'h000, 8'h78);
        rd(12'h000, 8'h78);
        apb(1'b1, 12'h004, 8'h0A);
        rd(12'h004, 8'h00);
        `CHK(cfg, 3'b000)
        apb(1'b1, 12'h004, 8'hF5);
        apb(1'b1, 12'h000, 8'h00);
        pulse_tmr();
        rd(12'h000, 8'h04);
        `CHK(o_irq_request, 1'b0)
        rd(12'h000, 8'h04);
        apb(1'b1, 12'h000, 8'h00);
        rd(12'h000, 8'h00);
        rd(12'h00C, 8'h01);
        apb(1'b1, 12'h010, 8'h01);
        `CHK(o_irq, 1'b1)
        apb(1'b1, 12'h010, 8'h00);
        `CHK(o_irq, 1'b0)
        apb(1'b1, 12'h010, 8'h01);
        apb(1'b1, 12'h00C, 8'h0F);
        `CHK(o_irq, 1'b0)
        rd(12'h00C, 8'h00);
        apb(1'b1, 12'h020, 8'hFF);
        `CHK(err, 1'b1)
        rd(12'h020, 8'h00);
        // Flag is clear before the enable goes on
        apb(1'b1, 12'h000, 8'hA0);
        pulse_tmr();
        `CHK(o_irq_request, 1'b1)
        `CHK(o_vector_addr, 24'h00_0008)
        dly <= 4'h3;
        auto <= 1'b1;
        wait_req(1'b0);
        auto <= 1'b0;
        rd(12'h000, 8'h24);
        rd(12'h00C, 8'h09);
        do_return(1'b0);
        rd(12'h000, 8'hA4);
        rd(12'h014, 8'h05);
        apb(1'b1, 12'h000, 8'h00);
        `CHK(o_irq_request, 1'b0)
        x0_pin <= 1'b1;
        tick(6);
        rd(12'h000, 8'h02);
        apb(1'b1, 12'h004, 8'hB5);
        apb(1'b1, 12'h000, 8'h00);
        x0_pin <= 1'b0;
        tick(6);
        rd(12'h000, 8'h02);
        apb(1'b1, 12'h000, 8'h00);
        x0_pin <= 1'b1;
        tick(6);
        rd(12'h000, 8'h00);
        pb <= 4'h5;
        tick(6);
        rd(12'h000, 8'h01);
        apb(1'b1, 12'h000, 8'h00);
        rd(12'h000, 8'h01);
        pb_rd <= 1'b1;
        tick(1);
        pb_rd <= 1'b0;
        tick(1);
        apb(1'b1, 12'h000, 8'h00);
        rd(12'h000, 8'h00);
        // Priority levels on, timer source set to low priority
        apb(1'b1, 12'h008, 8'h01);
        apb(1'b1, 12'h004, 8'hF1);
        apb(1'b1, 12'h000, 8'hA0);
        pulse_tmr();
        `CHK(o_irq_request, 1'b0)
        apb(1'b1, 12'h000, 8'hE4);
        `CHK(o_irq_request, 1'b1)
        `CHK(o_irq_high_level, 1'b0)
        `CHK(o_vector_addr, 24'h00_0018)
        dly <= 4'h0;
        auto <= 1'b1;
        wait_req(1'b0);
        auto <= 1'b0;
        rd(12'h000, 8'hA4);
        apb(1'b1, 12'h004, 8'hF5);
        `CHK(o_irq_high_level, 1'b1)
        `CHK(o_irq_request, 1'b1)
        apb(1'b1, 12'h000, 8'h64);
        `CHK(o_irq_request, 1'b0)
        // Back to single level: priority bits must not matter
        apb(1'b1, 12'h008, 8'h00);
        apb(1'b1, 12'h004, 8'hF1);
        apb(1'b1, 12'h000, 8'hA4);
        `CHK(o_irq_high_level, 1'b1)
        `CHK(o_vector_addr, 24'h00_0008)
        apb(1'b1, 12'h000, 8'h80);
        p_lo <= 1'b1;
        tick(2);
        `CHK(o_irq_request, 1'b0)
        apb(1'b1, 12'h000, 8'hC0);
        `CHK(o_irq_request, 1'b1)
        p_lo <= 1'b0;
        tick(2);
        // High level peripheral request needs only bit seven
        apb(1'b1, 12'h008, 8'h01);
        rd(12'h008, 8'h01);
        apb(1'b1, 12'h000, 8'h80);
        p_hi <= 1'b1;
        tick(2);
        `CHK(o_irq_request, 1'b1)
        `CHK(o_irq_high_level, 1'b1)
        apb(1'b1, 12'h000, 8'h00);
        `CHK(o_irq_request, 1'b0)
        p_hi <= 1'b0;
        tick(2);
        end_of_test();
    end
endmodule // testbench

// [design/iefc_defines.vh]
// Register map, field positions and reset values of the interrupt control
`ifndef IEFC_DEFINES_VH
`define IEFC_DEFINES_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define IEFC_OFS_MAIN 12'h000
`define IEFC_OFS_SECOND 12'h004
`define IEFC_OFS_PRIO_CTRL 12'h008
`define IEFC_OFS_EVT_STATUS 12'h00C
`define IEFC_OFS_EVT_MASK 12'h010
`define IEFC_OFS_CORE_STATE 12'h014

// ----------------------------------------------------------------------
// Main control register fields
// ----------------------------------------------------------------------
`define IEFC_MAIN_GLOBAL 7
`define IEFC_MAIN_PERIPH 6
`define IEFC_MAIN_TZ_EN 5
`define IEFC_MAIN_X0_EN 4
`define IEFC_MAIN_PC_EN 3
`define IEFC_MAIN_TZ_FLAG 2
`define IEFC_MAIN_X0_FLAG 1
`define IEFC_MAIN_PC_FLAG 0
`define IEFC_MAIN_RESET 8'h00

// ----------------------------------------------------------------------
// Second control register fields
// ----------------------------------------------------------------------
`define IEFC_SEC_PULLUP_DIS 7
`define IEFC_SEC_X0_EDGE 6
`define IEFC_SEC_X1_EDGE 5
`define IEFC_SEC_X2_EDGE 4
`define IEFC_SEC_TZ_PRIO 2
`define IEFC_SEC_PC_PRIO 0
`define IEFC_SEC_IMPL 8'hF5
`define IEFC_SEC_RESET 8'hF5

// ----------------------------------------------------------------------
// Event status, mask and core state fields
// ----------------------------------------------------------------------
`define IEFC_EVT_TZ 0
`define IEFC_EVT_X0 1
`define IEFC_EVT_PC 2
`define IEFC_EVT_TAKEN 3
`define IEFC_EVT_W 4
`define IEFC_EVT_RESET 4'h0
`define IEFC_CORE_HIGH 0
`define IEFC_CORE_LOW 1
`define IEFC_CORE_PRIO 2

// ----------------------------------------------------------------------
// Vectors and timing
// ----------------------------------------------------------------------
`define IEFC_VEC_HIGH 24'h00_0008
`define IEFC_VEC_LOW 24'h00_0018
`define IEFC_SYNC_SETTLE 2'h3

`endif

// [design/iefc_pin_event.v]
// Two-stage pin synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module iefc_pin_event #(
    parameter WIDTH = 1
) (
    input wire i_clock,
    input wire i_reset_n,
    input wire [WIDTH-1:0] i_pins,
    output wire [WIDTH-1:0] o_level,
    output wire [WIDTH-1:0] o_rise,
    output wire [WIDTH-1:0] o_fall
);

    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------
    // The first stage feeds only the second stage, never any logic
    reg [WIDTH-1:0] meta_reg;
    reg [WIDTH-1:0] sync_reg;
    reg [WIDTH-1:0] prev_reg;

    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            meta_reg <= {WIDTH{1'b0}};
            sync_reg <= {WIDTH{1'b0}};
            prev_reg <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= i_pins;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign o_level = sync_reg;
    assign o_rise = sync_reg & ~prev_reg;
    assign o_fall = ~sync_reg & prev_reg;

endmodule // iefc_pin_event

// [design/iefc_top.v]
// Core interrupt enable, flag and priority control with an APB slave
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "iefc_defines.vh"

// Overview of operation
// - Flags set on their source event regardless of any enable bit.
// - Main and second control registers are readable and writable.
// - Timer-zero overflow enable gates the timer-zero interrupt request.
// - Timer-zero flag sets on overflow and holds until software clears.
// - Flags stay readable while enables are clear, allowing polling.
// - With priority levels, bit seven enables all high priority sources.
// - With priority levels, bit six together with bit seven enables all low priority sources.
// - Without priority levels, priority bits ignored; single vector used.
// - Accepting an interrupt clears the enable bit of its level: bit seven, or bit six for a low level acceptance.
module iefc_top (
    input wire i_clock,
    input wire i_reset_n,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [11:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire [31:0] o_prdata,
    output wire o_pready,
    output wire o_pslverr,
    input wire i_timer_zero_overflow,
    input wire i_external_irq_zero_pin,
    input wire [3:0] i_port_b_pins,
    input wire i_port_b_read,
    input wire i_periph_high_irq,
    input wire i_periph_low_irq,
    input wire i_irq_accept,
    input wire i_irq_return,
    input wire i_return_high,
    output wire o_irq_request,
    output wire o_irq_high_level,
    output wire [23:0] o_vector_addr,
    output wire o_port_pullup_disable,
    output wire o_external_irq_one_edge,
    output wire o_external_irq_two_edge,
    output wire o_irq
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function sel_hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            sel_hit = (addr == ofs);
        end
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg [7:0] main_reg;
    reg [7:0] main_next;
    reg [7:0] second_reg;
    reg priority_levels_enable_reg;
    reg [`IEFC_EVT_W-1:0] evt_status_reg;
    reg [`IEFC_EVT_W-1:0] evt_status_next;
    reg [`IEFC_EVT_W-1:0] evt_mask_reg;
    reg [31:0] prdata_reg;
    reg [31:0] read_mux;
    reg [3:0] port_latch_reg;
    reg [1:0] settle_reg;
    reg in_high_reg;
    reg in_high_next;

    wire wr_access;
    wire rd_setup;
    wire mapped;
    wire x0_level;
    wire x0_rise;
    wire x0_fall;
    wire [3:0] port_level;
    wire tz_event;
    wire x0_event;
    wire pc_event;
    wire settled;

    // Field aliases
    wire global_or_high_level_enable = main_reg[`IEFC_MAIN_GLOBAL];
    wire peripheral_or_low_level_enable = main_reg[`IEFC_MAIN_PERIPH];
    wire timer_zero_overflow_enable = main_reg[`IEFC_MAIN_TZ_EN];
    wire external_irq_zero_enable = main_reg[`IEFC_MAIN_X0_EN];
    wire port_change_enable = main_reg[`IEFC_MAIN_PC_EN];
    wire timer_zero_overflow_flag = main_reg[`IEFC_MAIN_TZ_FLAG];
    wire external_irq_zero_flag = main_reg[`IEFC_MAIN_X0_FLAG];
    wire port_change_flag = main_reg[`IEFC_MAIN_PC_FLAG];
    wire external_irq_zero_edge = second_reg[`IEFC_SEC_X0_EDGE];
    wire timer_zero_overflow_priority = second_reg[`IEFC_SEC_TZ_PRIO];
    wire port_change_priority = second_reg[`IEFC_SEC_PC_PRIO];

    // ------------------------------------------------------------------
    // Source events
    // ------------------------------------------------------------------
    wire [3:0] x0_fall_unused_r;
    wire [3:0] x0_fall_unused_f;

    iefc_pin_event #(
        .WIDTH(5)
    ) u_pins (
        .i_clock(i_clock),
        .i_reset_n(i_reset_n),
        .i_pins({i_external_irq_zero_pin, i_port_b_pins}),
        .o_level({x0_level, port_level}),
        .o_rise({x0_rise, x0_fall_unused_r}),
        .o_fall({x0_fall, x0_fall_unused_f})
    );

    // Edge select: one picks the rising edge, zero the falling edge;
    // edges wait for the synchroniser to settle, so a pin held high
    // through reset does not look like a rising edge
    assign x0_event = settled &&
        (external_irq_zero_edge ? x0_rise : x0_fall);
    assign tz_event = i_timer_zero_overflow;
    // Port latch is primed until the synchroniser settles, so reset
    // itself never looks like a port change
    assign settled = (settle_reg == `IEFC_SYNC_SETTLE);
    assign pc_event = settled && (port_level != port_latch_reg);

    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            settle_reg <= 2'h0;
            port_latch_reg <= 4'h0;
        end else begin
            if (!settled) begin
                settle_reg <= settle_reg + 2'h1;
            end
            // A port read ends the mismatch by refreshing the latch
            if (!settled || i_port_b_read) begin
                port_latch_reg <= port_level;
            end
        end
    end

    // ------------------------------------------------------------------
    // Request and vector logic
    // ------------------------------------------------------------------
    wire tz_pend = timer_zero_overflow_enable & timer_zero_overflow_flag;
    wire x0_pend = external_irq_zero_enable & external_irq_zero_flag;
    wire pc_pend = port_change_enable & port_change_flag;
    wire periph_any = i_periph_high_irq | i_periph_low_irq;

    // Without priority levels every source goes to the single vector
    wire compat_req = global_or_high_level_enable &
        (tz_pend | x0_pend | pc_pend |
        (peripheral_or_low_level_enable & periph_any));

    // External interrupt zero has no priority bit and is always high
    wire high_src = (tz_pend & timer_zero_overflow_priority) | x0_pend |
        (pc_pend & port_change_priority) | i_periph_high_irq;
    wire low_src = (tz_pend & ~timer_zero_overflow_priority) |
        (pc_pend & ~port_change_priority) | i_periph_low_irq;
    wire high_req = global_or_high_level_enable & high_src;
    // Low level also waits on bit seven, so a high handler is not
    // interrupted by a low source
    wire low_req = peripheral_or_low_level_enable &
        global_or_high_level_enable & low_src;

    wire prio_mode = priority_levels_enable_reg;
    wire req_high_sel = prio_mode ? high_req : compat_req;
    assign o_irq_request = prio_mode ? (high_req | low_req) : compat_req;
    assign o_irq_high_level = req_high_sel;
    assign o_vector_addr = req_high_sel ? `IEFC_VEC_HIGH :
        `IEFC_VEC_LOW;

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Always ready: read data is captured in the setup cycle so it can
    // come from a flip-flop without adding a wait state
    assign mapped = sel_hit(i_paddr, `IEFC_OFS_MAIN) ||
        sel_hit(i_paddr, `IEFC_OFS_SECOND) ||
        sel_hit(i_paddr, `IEFC_OFS_PRIO_CTRL) ||
        sel_hit(i_paddr, `IEFC_OFS_EVT_STATUS) ||
        sel_hit(i_paddr, `IEFC_OFS_EVT_MASK) ||
        sel_hit(i_paddr, `IEFC_OFS_CORE_STATE);
    assign wr_access = i_psel & i_penable & i_pwrite & mapped;
    assign rd_setup = i_psel & ~i_penable & ~i_pwrite;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~mapped;
    assign o_prdata = prdata_reg;

    always @* begin
        read_mux = 32'h0000_0000;
        if (sel_hit(i_paddr, `IEFC_OFS_MAIN)) begin
            read_mux[7:0] = main_reg;
        end else if (sel_hit(i_paddr, `IEFC_OFS_SECOND)) begin
            read_mux[7:0] = second_reg;
        end else if (sel_hit(i_paddr, `IEFC_OFS_PRIO_CTRL)) begin
            read_mux[0] = priority_levels_enable_reg;
        end else if (sel_hit(i_paddr, `IEFC_OFS_EVT_STATUS)) begin
            read_mux[`IEFC_EVT_W-1:0] = evt_status_reg;
        end else if (sel_hit(i_paddr, `IEFC_OFS_EVT_MASK)) begin
            read_mux[`IEFC_EVT_W-1:0] = evt_mask_reg;
        end else if (sel_hit(i_paddr, `IEFC_OFS_CORE_STATE)) begin
            read_mux[`IEFC_CORE_HIGH] = prio_mode ? high_req : compat_req;
            read_mux[`IEFC_CORE_LOW] = prio_mode & low_req;
            read_mux[`IEFC_CORE_PRIO] = in_high_reg;
        end
    end

    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_reg <= read_mux;
        end
    end

    // ------------------------------------------------------------------
    // Main control register
    // ------------------------------------------------------------------
    wire wr_main = wr_access && sel_hit(i_paddr, `IEFC_OFS_MAIN);
    wire take_high = prio_mode ? high_req : 1'b1;

    always @* begin
        main_next = main_reg;
        in_high_next = in_high_reg;
        if (wr_main) begin
            main_next = i_pwdata[7:0];
        end
        // Core return re-arms the enable it left cleared
        if (i_irq_return) begin
            if (!prio_mode || i_return_high) begin
                main_next[`IEFC_MAIN_GLOBAL] = 1'b1;
            end else begin
                main_next[`IEFC_MAIN_PERIPH] = 1'b1;
            end
        end
        // Acceptance holds off further requests at the same level
        if (i_irq_accept && o_irq_request) begin
            in_high_next = take_high;
            if (take_high) begin
                main_next[`IEFC_MAIN_GLOBAL] = 1'b0;
            end else begin
                main_next[`IEFC_MAIN_PERIPH] = 1'b0;
            end
        end
        // Source events win over a software clear in the same cycle
        if (tz_event) begin
            main_next[`IEFC_MAIN_TZ_FLAG] = 1'b1;
        end
        if (x0_event) begin
            main_next[`IEFC_MAIN_X0_FLAG] = 1'b1;
        end
        if (pc_event) begin
            main_next[`IEFC_MAIN_PC_FLAG] = 1'b1;
        end
    end

    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            main_reg <= `IEFC_MAIN_RESET;
            in_high_reg <= 1'b0;
        end else begin
            main_reg <= main_next;
            in_high_reg <= in_high_next;
        end
    end

    // ------------------------------------------------------------------
    // Second control and priority mode registers
    // ------------------------------------------------------------------
    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            second_reg <= `IEFC_SEC_RESET;
            priority_levels_enable_reg <= 1'b0;
        end else if (wr_access) begin
            if (sel_hit(i_paddr, `IEFC_OFS_SECOND)) begin
                // Unimplemented bits stay zero
                second_reg <= i_pwdata[7:0] & `IEFC_SEC_IMPL;
            end
            if (sel_hit(i_paddr, `IEFC_OFS_PRIO_CTRL)) begin
                priority_levels_enable_reg <= i_pwdata[0];
            end
        end
    end

    // Pull-up control: one disables the port pull-ups
    assign o_port_pullup_disable = second_reg[`IEFC_SEC_PULLUP_DIS];
    assign o_external_irq_one_edge = second_reg[`IEFC_SEC_X1_EDGE];
    assign o_external_irq_two_edge = second_reg[`IEFC_SEC_X2_EDGE];

    // ------------------------------------------------------------------
    // Event status, mask and interrupt line
    // ------------------------------------------------------------------
    wire [`IEFC_EVT_W-1:0] evt_set = {
        i_irq_accept & o_irq_request, pc_event, x0_event, tz_event};
    wire wr_status = wr_access && sel_hit(i_paddr, `IEFC_OFS_EVT_STATUS);

    always @* begin
        evt_status_next = evt_status_reg;
        if (wr_status) begin
            evt_status_next = evt_status_reg &
                ~i_pwdata[`IEFC_EVT_W-1:0];
        end
        // Set wins over a write-one clear in the same cycle
        evt_status_next = evt_status_next | evt_set;
    end

    always @(posedge i_clock) begin
        if (!i_reset_n) begin
            evt_status_reg <= `IEFC_EVT_RESET;
            evt_mask_reg <= `IEFC_EVT_RESET;
        end else begin
            evt_status_reg <= evt_status_next;
            if (wr_access && sel_hit(i_paddr, `IEFC_OFS_EVT_MASK)) begin
                evt_mask_reg <= i_pwdata[`IEFC_EVT_W-1:0];
            end
        end
    end

    assign o_irq = |(evt_status_reg & evt_mask_reg);

endmodule // iefc_top
